// ### src/current_source_pkg.sv
package current_source_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [3:0] OFS_CONTROL = 4'h0;

  // field positions within the 16-bit control word
  localparam int unsigned TRIM_LSB  = 10;
  localparam int unsigned TRIM_W    = 6;
  localparam int unsigned RANGE_LSB = 8;
  localparam int unsigned RANGE_W   = 2;

  // reset values
  localparam logic [5:0] TRIM_RST  = 6'h00;
  localparam logic [1:0] RANGE_RST = 2'h0;

  // read data for an unmapped address
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // range select codes
  typedef enum logic [1:0] {
    RANGE_OFF    = 2'b00,
    RANGE_BASE   = 2'b01,
    RANGE_X10    = 2'b10,
    RANGE_X100   = 2'b11
  } range_t;

endpackage : current_source_pkg

// ### src/current_source_control.sv
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
`default_nettype none

module current_source_control
  import current_source_pkg::*;
(
  // clock and reset
  input  wire logic                               I_CLK,
  input  wire logic                               I_RST,
  // avalon-mm slave
  input  wire logic [current_source_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic                               I_AVS_READ,
  input  wire logic                               I_AVS_WRITE,
  input  wire logic [current_source_pkg::DATA_W-1:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]                         I_AVS_BYTEENABLE,
  output logic [current_source_pkg::DATA_W-1:0]   O_AVS_READDATA,
  output logic                                    O_AVS_WAITREQUEST,
  // analog current source controls
  output logic signed [5:0]                       O_TRIM_CODE,
  output logic [1:0]                              O_RANGE_SEL,
  output logic                                    O_SOURCE_ENABLE,
  output logic [2:0]                              O_RANGE_DECADE
);
  import current_source_pkg::*;

  logic [5:0]  trim_r;
  logic [1:0]  range_r;
  logic [31:0] rdata_r;
  logic        ack_r;

  // byte lane carrying bits 15 to 8, the only lane with storage behind it
  localparam int unsigned CTRL_LANE = RANGE_LSB / 8;

  // decode: every request waits exactly one cycle, so read data can come
  // from a flop rather than a combinational mux straight onto the bus; the
  // price is one extra cycle per access
  wire         sel_ctrl  = (I_AVS_ADDRESS == OFS_CONTROL);
  wire         req       = I_AVS_READ | I_AVS_WRITE;
  wire         rd_first  = I_AVS_READ & ~ack_r;
  wire         wr_take   = I_AVS_WRITE & ack_r & sel_ctrl;
  wire         hi_lane   = I_AVS_BYTEENABLE[CTRL_LANE];
  wire [15:0]  ctrl_word = {trim_r, range_r, 8'h00};
  wire [31:0]  rd_word   = sel_ctrl ? {16'h0000, ctrl_word} : UNMAPPED_DATA;
  wire         ack_nxt   = req & ~ack_r;
  wire [31:0]  rdata_nxt = rd_first ? rd_word : rdata_r;

  assign O_AVS_WAITREQUEST = req & ~ack_r;
  assign O_AVS_READDATA    = rdata_r;

  // handshake walk for one request:
  //   cycle 0: read or write seen with ack_r low, waitrequest high
  //   cycle 1: ack_r high, waitrequest low, the master completes at the edge
  //   the edge ending cycle 1 stores a write and drops ack_r again, so a
  //   back-to-back request sees its own wait cycle
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // read data is captured in the wait cycle and then stands until the next
  // read, so the bus always sees a flop output at the completing edge
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // control fields; low byte lane has no storage at all
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      trim_r  <= TRIM_RST;
      range_r <= RANGE_RST;
    end else if (wr_take & hi_lane) begin
      trim_r  <= I_AVS_WRITEDATA[TRIM_LSB +: TRIM_W];
      range_r <= I_AVS_WRITEDATA[RANGE_LSB +: RANGE_W];
    end
  end

  // trim is passed signed: zero nominal, positive up, negative down
  assign O_TRIM_CODE     = $signed(trim_r);
  assign O_RANGE_SEL     = range_r;
  assign O_SOURCE_ENABLE = (range_t'(range_r) != RANGE_OFF);

  // one-hot decade strobe for the analog mirror: base, x10, x100
  function automatic logic [2:0] decade_of(input logic [1:0] r);
    unique case (range_t'(r))
      RANGE_OFF:  decade_of = 3'b000;
      RANGE_BASE: decade_of = 3'b001;
      RANGE_X10:  decade_of = 3'b010;
      RANGE_X100: decade_of = 3'b100;
    endcase
  endfunction : decade_of

  assign O_RANGE_DECADE = decade_of(range_r);

  // write path: a stored write puts exactly the bus data into the fields
  chk_trim_write: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_take & hi_lane |=> trim_r == $past(I_AVS_WRITEDATA[15:10]))
    else $error("trim field did not take write");

  chk_range_write: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_take & hi_lane |=> O_RANGE_SEL == $past(I_AVS_WRITEDATA[9:8]))
    else $error("range field did not take write");

  // read path: register image, low byte, bus padding and unmapped reads
  chk_low_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_AVS_READ && sel_ctrl && !O_AVS_WAITREQUEST |-> O_AVS_READDATA[7:0] == 8'h00)
    else $error("low byte not zero");

  chk_readback: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_AVS_READ && sel_ctrl && !O_AVS_WAITREQUEST
      |-> O_AVS_READDATA == {16'h0000, trim_r, range_r, 8'h00})
    else $error("read back mismatch");

  chk_read_upper: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_AVS_READ && !O_AVS_WAITREQUEST |-> O_AVS_READDATA[31:16] == 16'h0000)
    else $error("upper read half not zero");

  chk_unmapped_read: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_AVS_READ && !sel_ctrl && !O_AVS_WAITREQUEST |-> O_AVS_READDATA == UNMAPPED_DATA)
    else $error("unmapped read not zero");

  chk_read_fresh: assert property (@(posedge I_CLK) disable iff (I_RST)
    rd_first |=> O_AVS_READDATA == $past(rd_word))
    else $error("read data not captured in wait cycle");

  chk_rdata_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
    !rd_first |=> $stable(O_AVS_READDATA))
    else $error("read data moved without a read");

  // analog decode: source enable, one-hot decade strobes and trim sign
  chk_range_off: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_RANGE_SEL == 2'b00) == (!O_SOURCE_ENABLE && O_RANGE_DECADE == 3'b000))
    else $error("range zero must disable source");

  chk_range_dec: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_RANGE_SEL != 2'b00 |-> O_RANGE_DECADE == (3'b001 << (O_RANGE_SEL - 2'b01)))
    else $error("decade strobe wrong");

  chk_decade_onehot: assert property (@(posedge I_CLK) disable iff (I_RST)
    $onehot0(O_RANGE_DECADE))
    else $error("more than one decade strobe");

  chk_enable_decade: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_SOURCE_ENABLE == (O_RANGE_DECADE != 3'h0))
    else $error("enable and decade strobe disagree");

  chk_trim_sign: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_TRIM_CODE > 0) == (!trim_r[5] && trim_r != 6'h00))
    else $error("trim sign wrong");

  chk_trim_negative: assert property (@(posedge I_CLK) disable iff (I_RST)
    trim_r[5] == (O_TRIM_CODE < 0))
    else $error("negative trim not below nominal");

  chk_trim_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
    trim_r == 6'h00 |-> O_TRIM_CODE == 0)
    else $error("zero trim not nominal");

  // the fields move only on a stored write and clear while reset is held
  chk_hold_idle: assert property (@(posedge I_CLK) disable iff (I_RST)
    !wr_take |=> $stable(trim_r) && $stable(range_r))
    else $error("field changed without write");

  chk_lane_refuse: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_AVS_WRITE && !O_AVS_WAITREQUEST && !hi_lane |=> $stable(trim_r) && $stable(range_r))
    else $error("write without the control lane changed a field");

  chk_unmapped_write: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_AVS_WRITE && !O_AVS_WAITREQUEST && !sel_ctrl |=> $stable(trim_r) && $stable(range_r))
    else $error("unmapped write changed a field");

  // judged from the second reset edge on, so the very first edge, which may
  // race the start of the run, never counts
  chk_reset_clear: assert property (@(posedge I_CLK)
    I_RST ##1 I_RST |-> trim_r == TRIM_RST && range_r == RANGE_RST && !O_AVS_WAITREQUEST)
    else $error("fields not clear during reset");

  // handshake: exactly one wait cycle for every request
  chk_wait_once: assert property (@(posedge I_CLK) disable iff (I_RST)
    req && !ack_r |-> O_AVS_WAITREQUEST ##1 (!req || !O_AVS_WAITREQUEST))
    else $error("waitrequest longer than one cycle");

  chk_wait_single: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("waitrequest high two cycles in a row");

  chk_ack_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
    ack_r |=> !ack_r)
    else $error("acknowledge held past one cycle");

  // the main scenarios the bench is expected to reach
  cov_write_x100: cover property (@(posedge I_CLK) disable iff (I_RST)
    wr_take & hi_lane ##1 O_RANGE_SEL == 2'b11);

  cov_neg_trim: cover property (@(posedge I_CLK) disable iff (I_RST)
    trim_r == 6'h20);

  cov_read_back: cover property (@(posedge I_CLK) disable iff (I_RST)
    I_AVS_READ && sel_ctrl && !O_AVS_WAITREQUEST && trim_r != 6'h00);

  cov_lane_refused: cover property (@(posedge I_CLK) disable iff (I_RST)
    I_AVS_WRITE && !O_AVS_WAITREQUEST && !hi_lane);

  cov_unmapped_read: cover property (@(posedge I_CLK) disable iff (I_RST)
    I_AVS_READ && !sel_ctrl && !O_AVS_WAITREQUEST);

endmodule : current_source_control

`default_nettype wire

// ### test/current_source_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module current_source_control_tb;
  import current_source_pkg::*;
  logic              clk, rst, rd, wr, wq, en;
  logic [3:0]        ad, be;
  logic [31:0]       wd, rdat, q;
  logic signed [5:0] trim;
  logic [1:0]        rng;
  logic [2:0]        dec;
  int                n_fail, total_checks, cyc;
  current_source_control dut (.I_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(ad), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wq), .O_TRIM_CODE(trim), .O_RANGE_SEL(rng), .O_SOURCE_ENABLE(en),
    .O_RANGE_DECADE(dec));
  // free-running 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // request held until the rising edge that samples waitrequest low; at that
  // edge the active region still sees the settled values of the cycle before
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= d;
    be <= b;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    wd <= ~d;
  endtask : bus
  // all analog controls in one word: trim, range, enable, one-hot decade
  task automatic outs(input logic [5:0] t, input logic [1:0] r);
    @(negedge clk);
    chk({20'h0_0000, trim, rng, en, dec}, {20'h0_0000, t, r, r != 0, r == 3, r == 2, r == 1});
  endtask : outs
  task automatic t_reset;
    outs(6'h00, 2'h0);
    bus(0, OFS_CONTROL, 32'h0000_0000, 4'hF);
    chk(q, 32'h0000_0000);
    $display("reset state test done");
  endtask : t_reset
  task automatic t_fields;
    logic [5:0] tv [5] = '{6'h20, 6'h3F, 6'h00, 6'h01, 6'h1F};
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 5; i++) begin
        bus(1, OFS_CONTROL, {16'hFFFF, tv[i], r[1:0], 8'hFF}, 4'hF);
        outs(tv[i], r[1:0]);
        bus(0, OFS_CONTROL, 32'h0000_0000, 4'hF);
        chk(q, {16'h0000, tv[i], r[1:0], 8'h00});
      end
    end
    $display("field test done");
  endtask : t_fields
  // unmapped address and missing byte lane must leave the register alone
  task automatic t_refuse;
    bus(1, OFS_CONTROL, 32'h0000_3E00, 4'hF);
    bus(1, 4'h4, 32'h0000_FD00, 4'hF);
    bus(1, OFS_CONTROL, 32'h0000_FD00, 4'hD);
    outs(6'h0F, 2'h2);
    bus(1, OFS_CONTROL, 32'h0000_8100, 4'h2);
    outs(6'h20, 2'h1);
    bus(0, 4'h4, 32'h0000_0000, 4'hF);
    chk(q, UNMAPPED_DATA);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    $display("refusal test done");
  endtask : t_refuse
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    rst = 1'b1; rd = 1'b0; wr = 1'b0; ad = 4'h0; wd = 32'h0000_0000; be = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_refuse();
    t_reset();
    give_verdict();
  end
endmodule : current_source_control_tb
`default_nettype wire
